// ---- hdl/dcg_pkg.sv ----
/*
  Package for the driver configuration and global status register bank:
  command layout, register addresses, field positions, reset values,
  frequency and slew codes, and the structs that carry them.
  Assumes an 8-bit register file reached through a 16-bit serial frame.
*/
package dcg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int unsigned DCG_FRAME_BITS = 16;
  localparam int unsigned DCG_BYTE_BITS = 8;
  localparam logic [4:0] DCG_CNT_ADDR_DONE = 5'h08;
  localparam logic [4:0] DCG_CNT_FRAME_DONE = 5'h10;
  localparam logic [4:0] DCG_CNT_MAX = 5'h1F;
  localparam int unsigned DCG_CMD_OP_BIT = 7;
  localparam int unsigned DCG_CMD_ADDR_HI = 6;
  localparam int unsigned DCG_CMD_ADDR_LO = 2;

  // Register addresses, bits 6..2 of the address byte
  localparam logic [4:0] DCG_ADDR_OVP_FAST = 5'h03;
  localparam logic [4:0] DCG_ADDR_OL_DT_SR = 5'h07;
  localparam logic [4:0] DCG_ADDR_GLOBAL_STATUS = 5'h06;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned DCG_OVP_SEL_BIT = 7;
  localparam int unsigned DCG_CH3_FAST_BIT = 6;
  localparam int unsigned DCG_CH2_FAST_BIT = 5;
  localparam int unsigned DCG_CH1_FAST_BIT = 4;
  localparam int unsigned DCG_OL_DIS_BIT = 6;
  localparam int unsigned DCG_DT_SEL_BIT = 5;
  localparam int unsigned DCG_SR_HI = 2;
  localparam int unsigned DCG_SR_LO = 0;

  localparam int unsigned DCG_ST_SPI_ERR_BIT = 7;
  localparam int unsigned DCG_ST_LOAD_ERR_BIT = 6;
  localparam int unsigned DCG_ST_UV_BIT = 5;
  localparam int unsigned DCG_ST_OV_BIT = 4;
  localparam int unsigned DCG_ST_NO_POWER_ON_RESET_FLAG_BIT = 3;
  localparam int unsigned DCG_ST_TSD_BIT = 2;
  localparam int unsigned DCG_ST_TPW_BIT = 1;

  // Bits that hold storage; all others read zero
  localparam logic [7:0] DCG_OVP_FAST_MASK = 8'hF0;
  localparam logic [7:0] DCG_OL_DT_SR_MASK = 8'h67;
  localparam logic [7:0] DCG_RESET_BYTE = 8'h00;
  localparam logic [7:0] DCG_ZERO_BYTE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Channel frequency field codes
  localparam logic [1:0] DCG_FREQ_CODE_STOP = 2'h0;
  localparam logic [1:0] DCG_FREQ_CODE_80 = 2'h1;
  localparam logic [1:0] DCG_FREQ_CODE_100 = 2'h2;
  localparam logic [1:0] DCG_FREQ_CODE_200 = 2'h3;

  // Resolved channel rate, one-hot
  typedef enum logic [4:0] {
    DCG_RATE_STOPPED = 5'b00001,
    DCG_RATE_80HZ = 5'b00010,
    DCG_RATE_100HZ = 5'b00100,
    DCG_RATE_200HZ = 5'b01000,
    DCG_RATE_2KHZ = 5'b10000
  } dcg_rate_t;

  // Slew rate codes, in tenths... named by rate
  typedef enum logic [2:0] {
    DCG_SR_0V35 = 3'h0,
    DCG_SR_0V2 = 3'h1,
    DCG_SR_0V5 = 3'h2,
    DCG_SR_0V6 = 3'h3,
    DCG_SR_1V7 = 3'h4,
    DCG_SR_1V0 = 3'h5,
    DCG_SR_2V4 = 3'h6,
    DCG_SR_3V0 = 3'h7
  } dcg_slew_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic high_overvoltage_threshold_sel;
    logic chan3_fast_freq_override;
    logic chan2_fast_freq_override;
    logic chan1_fast_freq_override;
    logic freewheel_openload_disable;
    logic dead_time_select;
    dcg_slew_t slew_rate_select;
  } dcg_config_t;

  typedef struct packed {
    dcg_rate_t chan3_rate;
    dcg_rate_t chan2_rate;
    dcg_rate_t chan1_rate;
  } dcg_rates_t;

  typedef struct packed {
    logic supply_undervoltage;
    logic supply_overvoltage;
    logic thermal_shutdown;
    logic thermal_prewarning;
    logic load_fault_any;
  } dcg_detect_t;

endpackage : dcg_pkg

// ---- hdl/dcg_regs.sv ----
/*
  Top of the driver configuration and global status register bank: two
  configuration bytes, the latched global status byte and the decoding of
  each serial command into read, write or clear.
  Assumes the analog detectors, the per-channel fault OR and the channel
  frequency register live outside and arrive as levels.
*/
`timescale 1ns/1ps
module dcg_regs (
  // System
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe_n,
  // Detectors and channel fault summary
  input wire dcg_pkg::dcg_detect_t detect_in,
  // Channel frequency fields from the frequency register, ch3..ch1
  input wire logic [5:0] channel_frequency_select_reg,
  // Configuration and control outputs
  output dcg_pkg::dcg_config_t config_out,
  output dcg_pkg::dcg_rates_t rates_out,
  output logic outputs_disable,
  output logic [7:0] global_status_out
);
  import dcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic dcg_rate_t dcg_resolve_rate(input logic fast, input logic [1:0] code);
    dcg_rate_t r;
    r = DCG_RATE_STOPPED;
    if (fast) begin
      r = DCG_RATE_2KHZ;
    end else if (code == DCG_FREQ_CODE_80) begin
      r = DCG_RATE_80HZ;
    end else if (code == DCG_FREQ_CODE_100) begin
      r = DCG_RATE_100HZ;
    end else if (code == DCG_FREQ_CODE_200) begin
      r = DCG_RATE_200HZ;
    end else begin
      r = DCG_RATE_STOPPED;
    end
    return r;
  endfunction : dcg_resolve_rate

  function automatic logic dcg_addr_is(input logic [7:0] cmd, input logic [4:0] addr);
    return cmd[DCG_CMD_ADDR_HI:DCG_CMD_ADDR_LO] == addr;
  endfunction : dcg_addr_is

  // Set wins over clear so an event in the clearing cycle is kept
  function automatic logic dcg_sticky_next(input logic cur, input logic evt, input logic clr);
    logic n;
    n = cur;
    if (evt) begin
      n = 1'b1;
    end else if (clr) begin
      n = 1'b0;
    end
    return n;
  endfunction : dcg_sticky_next

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] ovp_fast_reg;
  logic [7:0] ol_dt_sr_reg;
  logic spi_err_reg;
  logic uv_reg;
  logic ov_reg;
  logic no_power_on_reset_flag_reg;
  logic tsd_reg;
  logic tpw_reg;
  logic [1:0] uv_sync;
  logic [1:0] ov_sync;
  logic [1:0] tsd_sync;
  logic [1:0] tpw_sync;
  logic [1:0] le_sync;
  logic [7:0] status_byte;
  logic [7:0] read_byte;
  logic addr_valid;
  logic [7:0] addr_byte;
  logic frame_done;
  logic [15:0] frame_rx;
  logic frame_err;
  logic [7:0] cmd_byte;
  logic [7:0] data_byte;
  logic cmd_op;
  logic write_ovp;
  logic write_ol;
  logic clear_status;
  logic spi_err_next;
  logic uv_next;
  logic ov_next;
  logic tsd_next;
  logic tpw_next;
  logic no_power_on_reset_flag_next;

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine
  dcg_spi_frame u_frame (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso_out(miso_out),
    .miso_oe_n(miso_oe_n),
    .first_byte_tx(status_byte),
    .second_byte_tx(read_byte),
    .addr_valid(addr_valid),
    .addr_byte(addr_byte),
    .frame_done(frame_done),
    .frame_rx(frame_rx),
    .frame_err(frame_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode; effects happen only on a complete frame
  assign cmd_byte = frame_rx[15:8];
  assign data_byte = frame_rx[7:0];
  assign cmd_op = cmd_byte[DCG_CMD_OP_BIT];
  assign write_ovp = frame_done && cmd_op && dcg_addr_is(cmd_byte, DCG_ADDR_OVP_FAST);
  assign write_ol = frame_done && cmd_op && dcg_addr_is(cmd_byte, DCG_ADDR_OL_DT_SR);
  assign clear_status = frame_done && cmd_op && dcg_addr_is(cmd_byte, DCG_ADDR_GLOBAL_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Detector synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      uv_sync <= 2'h0;
    end else begin
      uv_sync <= {uv_sync[0], detect_in.supply_undervoltage};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ov_sync <= 2'h0;
    end else begin
      ov_sync <= {ov_sync[0], detect_in.supply_overvoltage};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tsd_sync <= 2'h0;
    end else begin
      tsd_sync <= {tsd_sync[0], detect_in.thermal_shutdown};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tpw_sync <= 2'h0;
    end else begin
      tpw_sync <= {tpw_sync[0], detect_in.thermal_prewarning};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      le_sync <= 2'h0;
    end else begin
      le_sync <= {le_sync[0], detect_in.load_fault_any};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration byte: threshold and fast overrides
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ovp_fast_reg <= DCG_RESET_BYTE;
    end else if (write_ovp) begin
      ovp_fast_reg <= data_byte & DCG_OVP_FAST_MASK;
    end
  end

  // Configuration byte: open-load mode, dead time, slew
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ol_dt_sr_reg <= DCG_RESET_BYTE;
    end else if (write_ol) begin
      ol_dt_sr_reg <= data_byte & DCG_OL_DT_SR_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched status flags. A new event wins over a clear in the same cycle,
  // and nothing but a clear command lowers a flag.
  assign spi_err_next = dcg_sticky_next(spi_err_reg, frame_err, clear_status);
  assign uv_next = dcg_sticky_next(uv_reg, uv_sync[1], clear_status);
  assign ov_next = dcg_sticky_next(ov_reg, ov_sync[1], clear_status);
  assign tsd_next = dcg_sticky_next(tsd_reg, tsd_sync[1], clear_status);
  assign tpw_next = dcg_sticky_next(tpw_reg, tpw_sync[1], clear_status);
  // Power-on marker: zero from reset until the master acknowledges by
  // clearing the status byte; after that it reports no reset since.
  assign no_power_on_reset_flag_next = no_power_on_reset_flag_reg || clear_status;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      spi_err_reg <= 1'b0;
    end else begin
      spi_err_reg <= spi_err_next;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      uv_reg <= 1'b0;
    end else begin
      uv_reg <= uv_next;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ov_reg <= 1'b0;
    end else begin
      ov_reg <= ov_next;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tsd_reg <= 1'b0;
    end else begin
      tsd_reg <= tsd_next;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tpw_reg <= 1'b0;
    end else begin
      tpw_reg <= tpw_next;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      no_power_on_reset_flag_reg <= 1'b0;
    end else begin
      no_power_on_reset_flag_reg <= no_power_on_reset_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte and read mux
  always_comb begin
    status_byte = DCG_ZERO_BYTE;
    status_byte[DCG_ST_SPI_ERR_BIT] = spi_err_reg;
    status_byte[DCG_ST_LOAD_ERR_BIT] = le_sync[1];
    status_byte[DCG_ST_UV_BIT] = uv_reg;
    status_byte[DCG_ST_OV_BIT] = ov_reg;
    status_byte[DCG_ST_NO_POWER_ON_RESET_FLAG_BIT] = no_power_on_reset_flag_reg;
    status_byte[DCG_ST_TSD_BIT] = tsd_reg;
    status_byte[DCG_ST_TPW_BIT] = tpw_reg;
  end

  // Reads never disturb state; unmapped addresses return zero
  always_comb begin
    if (dcg_addr_is(addr_byte, DCG_ADDR_OVP_FAST)) begin
      read_byte = ovp_fast_reg;
    end else if (dcg_addr_is(addr_byte, DCG_ADDR_OL_DT_SR)) begin
      read_byte = ol_dt_sr_reg;
    end else if (dcg_addr_is(addr_byte, DCG_ADDR_GLOBAL_STATUS)) begin
      read_byte = status_byte;
    end else begin
      read_byte = DCG_ZERO_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      config_out <= '0;
    end else begin
      config_out.high_overvoltage_threshold_sel <= ovp_fast_reg[DCG_OVP_SEL_BIT];
      config_out.chan3_fast_freq_override <= ovp_fast_reg[DCG_CH3_FAST_BIT];
      config_out.chan2_fast_freq_override <= ovp_fast_reg[DCG_CH2_FAST_BIT];
      config_out.chan1_fast_freq_override <= ovp_fast_reg[DCG_CH1_FAST_BIT];
      config_out.freewheel_openload_disable <= ol_dt_sr_reg[DCG_OL_DIS_BIT];
      config_out.dead_time_select <= ol_dt_sr_reg[DCG_DT_SEL_BIT];
      config_out.slew_rate_select <= dcg_slew_t'(ol_dt_sr_reg[DCG_SR_HI:DCG_SR_LO]);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rates_out <= {DCG_RATE_STOPPED, DCG_RATE_STOPPED, DCG_RATE_STOPPED};
    end else begin
      rates_out.chan3_rate <= dcg_resolve_rate(ovp_fast_reg[DCG_CH3_FAST_BIT],
                                               channel_frequency_select_reg[5:4]);
      rates_out.chan2_rate <= dcg_resolve_rate(ovp_fast_reg[DCG_CH2_FAST_BIT],
                                               channel_frequency_select_reg[3:2]);
      rates_out.chan1_rate <= dcg_resolve_rate(ovp_fast_reg[DCG_CH1_FAST_BIT],
                                               channel_frequency_select_reg[1:0]);
    end
  end

  // Outputs stay off until the fault flag is cleared, not just the fault
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      outputs_disable <= 1'b0;
    end else begin
      outputs_disable <= uv_reg || ov_reg || tsd_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      global_status_out <= DCG_RESET_BYTE;
    end else begin
      global_status_out <= status_byte;
    end
  end

endmodule : dcg_regs

// ---- hdl/dcg_spi_frame.sv ----
/*
  Serial frame engine: synchronises the serial pins, shifts a 16-bit frame
  MSB first (data out on rising clock, in on falling clock), reports the
  address byte and the finished frame, and flags malformed frames.
  Assumes the serial clock is at most a tenth of the system clock.
*/
`timescale 1ns/1ps
module dcg_spi_frame (
  // System
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe_n,
  // Register side
  input wire logic [7:0] first_byte_tx,
  input wire logic [7:0] second_byte_tx,
  output logic addr_valid,
  output logic [7:0] addr_byte,
  output logic frame_done,
  output logic [15:0] frame_rx,
  output logic frame_err
);
  import dcg_pkg::*;

  logic [2:0] sclk_sync;
  logic [2:0] cs_sync;
  logic [1:0] mosi_sync;
  logic [4:0] bit_cnt_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic selected;

  ////////////////////////////////////////////////////////////////////////////
  // Stage 0 only feeds stage 1; edges come from stages 1 and 2
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sclk_sync <= 3'h0;
      cs_sync <= 3'h7;
      mosi_sync <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk};
      cs_sync <= {cs_sync[1:0], cs_n};
      mosi_sync <= {mosi_sync[0], mosi};
    end
  end

  assign selected = !cs_sync[1];
  assign sclk_rise = selected && sclk_sync[1] && !sclk_sync[2];
  assign sclk_fall = selected && !sclk_sync[1] && sclk_sync[2];
  assign cs_fall = !cs_sync[1] && cs_sync[2];
  assign cs_rise = cs_sync[1] && !cs_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Receive side
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_reg <= 5'h00;
      rx_reg <= 16'h0000;
    end else if (cs_fall) begin
      bit_cnt_reg <= 5'h00;
    end else if (sclk_fall) begin
      rx_reg <= {rx_reg[14:0], mosi_sync[1]};
      if (bit_cnt_reg != DCG_CNT_MAX) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // Pulses for the register side
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addr_valid <= 1'b0;
      addr_byte <= 8'h00;
      frame_done <= 1'b0;
      frame_rx <= 16'h0000;
      frame_err <= 1'b0;
    end else begin
      addr_valid <= sclk_fall && (bit_cnt_reg == DCG_CNT_ADDR_DONE - 5'h01);
      if (sclk_fall && (bit_cnt_reg == DCG_CNT_ADDR_DONE - 5'h01)) begin
        addr_byte <= {rx_reg[6:0], mosi_sync[1]};
      end
      frame_done <= cs_rise && (bit_cnt_reg == DCG_CNT_FRAME_DONE);
      frame_err <= cs_rise && (bit_cnt_reg != DCG_CNT_FRAME_DONE);
      if (cs_rise) begin
        frame_rx <= rx_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side: status byte first, addressed byte second
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_reg <= 16'h0000;
      miso_out <= 1'b0;
    end else if (cs_fall) begin
      tx_reg <= {first_byte_tx, DCG_ZERO_BYTE};
    end else if (addr_valid) begin
      tx_reg <= {second_byte_tx, DCG_ZERO_BYTE};
    end else if (sclk_rise) begin
      miso_out <= tx_reg[15];
      tx_reg <= {tx_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= !selected;
    end
  end

endmodule : dcg_spi_frame

// ---- test/dcg_regs_properties.sv ----
/*
  Concurrent checks on the ports of the register bank top.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module dcg_regs_properties (
  // System
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched ports
  input wire logic cs_n,
  input wire logic miso_oe_n,
  input wire dcg_pkg::dcg_detect_t detect_in,
  input wire logic [5:0] channel_frequency_select_reg,
  input wire dcg_pkg::dcg_config_t config_out,
  input wire dcg_pkg::dcg_rates_t rates_out,
  input wire logic outputs_disable,
  input wire logic [7:0] global_status_out
);
  import dcg_pkg::*;
  logic cs_q;
  logic [4:0] since_rise;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since chip select last went high, saturating
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) cs_q <= 1'b1;
    else cs_q <= cs_n;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) since_rise <= 5'h1F;
    else if (cs_n && !cs_q) since_rise <= 5'h00;
    else if (since_rise != 5'h1F) since_rise <= since_rise + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync, latch and copy take four cycles; five samples span exactly those four
  sequence held5(s);
    s [*5];
  endsequence
  // Commands act only shortly after a frame closes
  sequence frame_closed;
    since_rise <= 5'h0C;
  endsequence
  property sets(d, b);
    held5(d) |-> b;
  endproperty

  status_bit0_a: assert property (global_status_out[0] == 1'b0)
    else $error("status bit 0 not zero");
  uv_latch_a: assert property (sets(detect_in.supply_undervoltage, global_status_out[5]))
    else $error("undervoltage flag not set");
  ov_latch_a: assert property (sets(detect_in.supply_overvoltage, global_status_out[4]))
    else $error("overvoltage flag not set");
  tsd_latch_a: assert property (sets(detect_in.thermal_shutdown, global_status_out[2]))
    else $error("shutdown flag not set");
  tpw_latch_a: assert property (sets(detect_in.thermal_prewarning, global_status_out[1]))
    else $error("prewarning flag not set");
  load_live_a: assert property (sets(detect_in.load_fault_any, global_status_out[6]))
    else $error("load error not raised");
  load_fall_a: assert property (sets(!detect_in.load_fault_any, !global_status_out[6]))
    else $error("load error not lowered");
  no_self_clear_a: assert property (
    |($past(global_status_out) & ~global_status_out & 8'hB6) |-> frame_closed)
    else $error("flag cleared without command");
  no_power_on_reset_flag_sticky_a: assert property (global_status_out[3] |=> global_status_out[3])
    else $error("power-on flag fell");
  cfg_after_frame_a: assert property (!$stable(config_out) |-> frame_closed)
    else $error("config changed outside frame end");
  disable_follow_a: assert property (
    $rose(|(global_status_out & 8'h34)) |-> ##[0:3] outputs_disable)
    else $error("outputs not disabled");
  prewarn_only_a: assert property (
    held5((global_status_out & 8'h34) == 8'h00) |-> !outputs_disable)
    else $error("outputs disabled without fault");
  fast_rate_a: assert property (
    config_out.chan2_fast_freq_override && $past(config_out.chan2_fast_freq_override)
    |-> rates_out.chan2_rate == DCG_RATE_2KHZ)
    else $error("override not 2 kHz");
  freq_rate_a: assert property (
    $past(reset_n) && !config_out.chan1_fast_freq_override
    && !$past(config_out.chan1_fast_freq_override)
    && $stable(channel_frequency_select_reg[1:0])
    |-> rates_out.chan1_rate == 5'(5'h01 << channel_frequency_select_reg[1:0]))
    else $error("channel rate wrong");
  oe_follow_a: assert property ($fell(cs_n) |-> ##[1:5] !miso_oe_n)
    else $error("miso not enabled");
endmodule : dcg_regs_properties

bind dcg_regs dcg_regs_properties u_props (.clk_sys, .reset_n, .cs_n, .miso_oe_n,
  .detect_in, .channel_frequency_select_reg, .config_out, .rates_out,
  .outputs_disable, .global_status_out);

// ---- test/dcg_regs_test.sv ----
/*
  Self-checking bench for the register bank through its serial port.
  Assumes the master model and the bound checker.
*/
`timescale 1ns/1ps
module dcg_regs_test;
  import dcg_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, cs_n, mosi, miso_out, miso_oe_n, outputs_disable;
  dcg_detect_t detect_in = '0;
  logic [5:0] freq = 6'h00;
  dcg_config_t config_out;
  dcg_rates_t rates_out;
  logic [7:0] global_status_out, d, prev, ex;
  logic [15:0] rx;
  logic [2:0] v;
  logic [7:0] st [4] = '{8'h20, 8'h10, 8'h04, 8'h02};
  logic [4:0] dt [4] = '{5'h10, 5'h08, 5'h04, 5'h02};
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #25 clk_sys = ~clk_sys;

  dcg_regs u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .detect_in(detect_in),
    .channel_frequency_select_reg(freq), .config_out(config_out), .rates_out(rates_out),
    .outputs_disable(outputs_disable), .global_status_out(global_status_out));
  dcg_spi_master u_mst (.clk_sys(clk_sys), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic wr(input logic [4:0] a, input logic [7:0] b);
    u_mst.xfer({1'b1, a, 2'b00, b}, 16, rx);
  endtask : wr

  task automatic rd(input logic [4:0] a);
    u_mst.xfer({1'b0, a, 2'b00, 8'h00}, 16, rx);
  endtask : rd

  // Hang guard, well above the expected run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    tick(5);
    reset_n = 1'b1;
    tick(2);
    check(16'(config_out), 16'h0000);
    check(16'(global_status_out), 16'h0000);
    check(16'(rates_out), 16'({3{DCG_RATE_STOPPED}}));
    rd(DCG_ADDR_GLOBAL_STATUS);
    check(rx, 16'h0000);
    wr(DCG_ADDR_OVP_FAST, 8'hFF);
    check(16'(config_out[8:5]), 16'h000F);
    check(16'(rates_out), 16'({3{DCG_RATE_2KHZ}}));
    wr(DCG_ADDR_OVP_FAST, 8'h00);
    check(16'(rx[7:0]), 16'h00F0);
    check(16'(config_out[8]), 16'h0000);
    for (int c = 0; c < 4; c++) begin
      freq = {3{2'(c)}};
      tick(4);
      check(16'(rates_out), 16'({3{5'(5'h01 << c)}}));
    end
    freq = {2'h1, 2'h2, 2'h3};
    wr(DCG_ADDR_OVP_FAST, 8'h20);
    check(16'(rates_out), 16'({DCG_RATE_80HZ, DCG_RATE_2KHZ, DCG_RATE_200HZ}));
    wr(DCG_ADDR_OL_DT_SR, 8'hFF);
    check(16'(config_out[4:3]), 16'h0003);
    prev = 8'h67;
    // Each write hands back the previous content as readback
    for (int c = 0; c < 8; c++) begin
      v = 3'(c);
      d = {1'b0, v[0], v[1], 2'b00, v};
      wr(DCG_ADDR_OL_DT_SR, d);
      check(16'(rx[7:0]), 16'(prev));
      check(16'(config_out[4:0]), 16'({v[0], v[1], v}));
      prev = d;
    end
    wr(5'h01, 8'hFF);
    check(16'(rx[7:0]), 16'h0000);
    check(16'(config_out), 16'h005F);
    rd(DCG_ADDR_OVP_FAST);
    check(rx, 16'h0020);
    check(16'(config_out), 16'h005F);
    for (int i = 0; i < 4; i++) begin
      ex = st[i] | (i > 0 ? 8'h08 : 8'h00);
      detect_in = dcg_detect_t'(dt[i]);
      tick(10);
      detect_in = '0;
      tick(10);
      check(16'(global_status_out), 16'(ex));
      check(16'(outputs_disable), 16'(i < 3));
      rd(DCG_ADDR_GLOBAL_STATUS);
      check(16'(rx[7:0]), 16'(ex));
      check(16'(global_status_out), 16'(ex));
      wr(DCG_ADDR_GLOBAL_STATUS, 8'hFF);
      check(16'(global_status_out), 16'h0008);
    end
    detect_in.load_fault_any = 1'b1;
    tick(8);
    check(16'(global_status_out), 16'h0048);
    wr(DCG_ADDR_GLOBAL_STATUS, 8'hFF);
    check(16'(global_status_out), 16'h0048);
    detect_in.load_fault_any = 1'b0;
    tick(8);
    check(16'(global_status_out), 16'h0008);
    // A detector still active during the clear keeps its flag
    detect_in.supply_undervoltage = 1'b1;
    tick(8);
    wr(DCG_ADDR_GLOBAL_STATUS, 8'hFF);
    check(16'(global_status_out), 16'h0028);
    check(16'(outputs_disable), 16'h0001);
    detect_in.supply_undervoltage = 1'b0;
    wr(DCG_ADDR_GLOBAL_STATUS, 8'hFF);
    check(16'(global_status_out), 16'h0008);
    check(16'(outputs_disable), 16'h0000);
    // Short frame must be refused and flagged
    u_mst.xfer({1'b1, DCG_ADDR_OVP_FAST, 2'b00, 8'hFF}, 15, rx);
    check(16'(global_status_out), 16'h0088);
    check(16'(config_out), 16'h005F);
    tick(40);
    check(16'(global_status_out), 16'h0088);
    wr(DCG_ADDR_GLOBAL_STATUS, 8'hFF);
    check(16'(global_status_out), 16'h0008);
    // Second reset in mid-run must restore the config and status defaults; rates then follow freq
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(2);
    check(16'(config_out), 16'h0000);
    check(16'(global_status_out), 16'h0000);
    check(16'(rates_out), 16'({DCG_RATE_80HZ, DCG_RATE_100HZ, DCG_RATE_200HZ}));
    results();
  end
endmodule : dcg_regs_test

// ---- test/dcg_spi_master.sv ----
/*
  Serial master model: mode 1 frames, MSB first, slow clock.
  Assumes the caller gives the frame and its bit count.
*/
`timescale 1ns/1ps
module dcg_spi_master (
  // System
  input wire logic clk_sys,
  // Serial pins
  input wire logic miso_out,
  input wire logic miso_oe_n,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  // Address byte then data byte; bit 7 of the address picks read or write
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    tick(8);
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      mosi = tx[15 - i];
      tick(8);
      sclk = 1'b0;
      // Undriven line reads as garbage, not the last bit
      rx = {rx[14:0], miso_oe_n ? ~rx[0] : miso_out};
      tick(8);
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    tick(16);
  endtask : xfer
endmodule : dcg_spi_master
